// >>> rtl/pilr_level_regs.sv
// Peripheral interrupt level registers and level arbitration
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Level register writes take effect only while the level scheme enable is set.
// - Every source owns a two-bit field; 00..11 mean levels 1..4.
// - Arbitration prefers the pending enabled source with the highest level.
// - All level fields reset to 00, level 1.
// - Serial register bits 1:0 sync serial, bits 3:2 sync serial with FIFO.
// - Serial register bits 5:4 two-wire channel 0, bits 7:6 channel 1.
// - Serial register bits 9:8 async receive, bits 11:10 async transmit.
// - Serial register bits 13:12 async with FIFO; bits 15:14 unused.
// - System register bits 11:10 oscillator, bits 13:12 voltage sense.
// - System register bits 15:14 melody generator 0.
// - Analog register bits 1:0 SAR converter, bits 3:2 RC converter.
// - Analog register bits 9:8 comparator 0, bits 11:10 comparator 1.
// - Analog register at 0F02AH, byte or word access, resets to 0000H.
// - A level only counts for sources enabled in the matching enable group.
// - Requests below the highest in-service level are refused.
module pilr_level_regs
  import pilr_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic resetn_i, // Async reset, active low
  input wire pilr_bus_req_type bus_i, // Register bus request
  input wire logic level_scheme_enable_i, // Level scheme enable
  input wire logic [PILR_NSRC-1:0] irq_pend_i, // Pending requests, source order
  input wire logic [6:0] serial_group_irq_enable_i, // Serial group enables
  input wire logic [2:0] system_group_irq_enable_i, // System group enables
  input wire logic [3:0] analog_group_irq_enable_i, // Analog group enables
  input wire logic [3:0] in_service_level_i, // Maskable levels in service
  output logic [15:0] rdata_o, // Registered read data
  output logic win_valid_o, // A request is accepted
  output logic [4:0] win_idx_o, // Winning source index
  output logic [2:0] win_level_o, // Winning level, 1 to 4
  output logic [PILR_NSRC*2-1:0] src_level_o // Level field per source
);
  pilr_state_type st_r, st_nxt;
  logic [PILR_NSRC*2-1:0] lv;
  logic [PILR_NSRC-1:0] en;
  logic [2:0] floor_lv;
  logic [2:0] src_lvl [PILR_NSRC];
  logic [PILR_NSRC-1:0] elig;

  // Source order: serial 0..6, system 7..9, converters 10..11, comparators 12..13
  assign lv[13:0] = st_r.serial_level[13:0];
  assign lv[19:14] = st_r.system_level[15:10];
  assign lv[23:20] = st_r.analog_level[3:0];
  assign lv[27:24] = st_r.analog_level[11:8];
  assign en[6:0] = serial_group_irq_enable_i;
  assign en[9:7] = system_group_irq_enable_i;
  assign en[13:10] = analog_group_irq_enable_i;

  // One decoder per source; keeps the arbiter loop to a plain compare
  for (genvar s = 0; s < PILR_NSRC; s++) begin : g_src
    assign src_lvl[s] = {1'b0, lv[s*2 +: 2]} + 3'h1;
    assign elig[s] = irq_pend_i[s] && en[s] && src_lvl[s] >= floor_lv;
  end

  // Highest level in service; a request at that same level still gets through
  always_comb begin
    floor_lv = 3'h0;
    for (int k = 0; k < 4; k++) begin
      if (in_service_level_i[k]) begin
        floor_lv = 3'(k + 1);
      end
    end
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input pilr_bus_req_type b,
                                        input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (b.be[0]) begin
      v[7:0] = b.wdata[7:0];
    end
    if (b.be[1]) begin
      v[15:8] = b.wdata[15:8];
    end
    return v & m;
  endfunction : merge

  always_comb begin
    logic wen;
    wen = 1'b0;
    st_nxt = st_r;
    wen = bus_i.wr && level_scheme_enable_i;
    if (wen && bus_i.addr == PILR_SERIAL_ADDR) begin
      st_nxt.serial_level = merge(st_r.serial_level, bus_i, PILR_SERIAL_MASK);
    end
    if (wen && bus_i.addr == PILR_SYSTEM_ADDR) begin
      st_nxt.system_level = merge(st_r.system_level, bus_i, PILR_SYSTEM_MASK);
    end
    if (wen && bus_i.addr == PILR_ANALOG_ADDR) begin
      st_nxt.analog_level = merge(st_r.analog_level, bus_i, PILR_ANALOG_MASK);
    end
    st_nxt.rdata = 16'h0000;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        PILR_SERIAL_ADDR: st_nxt.rdata = st_r.serial_level;
        PILR_SYSTEM_ADDR: st_nxt.rdata = st_r.system_level;
        PILR_ANALOG_ADDR: st_nxt.rdata = st_r.analog_level;
        default: st_nxt.rdata = 16'h0000;
      endcase
      if (!bus_i.be[0]) begin
        st_nxt.rdata[7:0] = 8'h00;
      end
      if (!bus_i.be[1]) begin
        st_nxt.rdata[15:8] = 8'h00;
      end
    end
    // Strict greater-than keeps the lowest index on ties
    st_nxt.win_valid = 1'b0;
    st_nxt.win_idx = 5'h00;
    st_nxt.win_level = PILR_NO_WINNER;
    for (int s = 0; s < PILR_NSRC; s++) begin
      if (elig[s] && src_lvl[s] > st_nxt.win_level) begin
        st_nxt.win_valid = 1'b1;
        st_nxt.win_idx = 5'(s);
        st_nxt.win_level = src_lvl[s];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign win_valid_o = st_r.win_valid;
  assign win_idx_o = st_r.win_idx;
  assign win_level_o = st_r.win_level;
  assign src_level_o = lv;

  // Word accesses taken on one edge
  sequence s_word_write(logic [15:0] a);
    bus_i.wr && level_scheme_enable_i && bus_i.addr == a && bus_i.be == 2'h3;
  endsequence

  sequence s_word_read(logic [15:0] a);
    bus_i.rd && bus_i.be == 2'h3 && bus_i.addr == a;
  endsequence

  a_write_gated: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !level_scheme_enable_i |=> $stable(st_r.analog_level) && $stable(st_r.serial_level)
      && $stable(st_r.system_level))
    else $error("level register changed while scheme disabled");

  a_analog_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_word_write(PILR_ANALOG_ADDR)
    |=> st_r.analog_level == ($past(bus_i.wdata) & PILR_ANALOG_MASK))
    else $error("analog level write lost");

  a_serial_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_word_write(PILR_SERIAL_ADDR)
    |=> st_r.serial_level == ($past(bus_i.wdata) & PILR_SERIAL_MASK))
    else $error("serial level write lost");

  a_system_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_word_write(PILR_SYSTEM_ADDR)
    |=> st_r.system_level == ($past(bus_i.wdata) & PILR_SYSTEM_MASK))
    else $error("system level write lost");

  // A byte write must leave the other byte alone
  a_low_byte_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    bus_i.wr && level_scheme_enable_i && bus_i.addr == PILR_ANALOG_ADDR && bus_i.be == 2'h1
    |=> st_r.analog_level[15:8] == $past(st_r.analog_level[15:8]))
    else $error("low byte write touched high byte");

  a_high_byte_only: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    bus_i.wr && level_scheme_enable_i && bus_i.addr == PILR_SERIAL_ADDR && bus_i.be == 2'h2
    |=> st_r.serial_level[7:0] == $past(st_r.serial_level[7:0]))
    else $error("high byte write touched low byte");

  a_unused_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    st_r.serial_level[15:14] == 2'h0 && st_r.analog_level[15:12] == 4'h0
      && st_r.analog_level[7:4] == 4'h0)
    else $error("unused level bits set");

  a_system_low: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    st_r.system_level[9:0] == 10'h000)
    else $error("system low bits set");

  a_win_enabled: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    win_valid_o |-> (($past(en & irq_pend_i) >> win_idx_o) & 1'b1) != '0)
    else $error("winner not enabled and pending");

  a_win_floor: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    win_valid_o |-> win_level_o >= $past(floor_lv))
    else $error("winner below in-service level");

  a_win_level: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    win_valid_o |-> win_level_o == 3'(($past(lv) >> (win_idx_o * 2)) & 2'h3) + 3'h1)
    else $error("winner level mismatch");

  // Any eligible source must produce a winner on the next edge
  a_win_any: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    |elig |=> win_valid_o)
    else $error("eligible request not arbitrated");

  a_win_none: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !(|elig) |=> !win_valid_o && win_level_o == 3'h0 && win_idx_o == 5'h00)
    else $error("winner without eligible request");

  a_win_idx_range: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    win_valid_o |-> 32'(win_idx_o) < PILR_NSRC)
    else $error("winner index out of range");

  a_read_data: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_word_read(PILR_SYSTEM_ADDR) |=> rdata_o == $past(st_r.system_level))
    else $error("system level read mismatch");

  a_read_serial: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_word_read(PILR_SERIAL_ADDR) |=> rdata_o == $past(st_r.serial_level))
    else $error("serial level read mismatch");

  a_read_analog: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_word_read(PILR_ANALOG_ADDR) |=> rdata_o == $past(st_r.analog_level))
    else $error("analog level read mismatch");

  // Reads stay live while writes are locked out
  a_disabled_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_word_read(PILR_ANALOG_ADDR) ##0 !level_scheme_enable_i
    |=> rdata_o == $past(st_r.analog_level))
    else $error("read blocked while scheme disabled");

  a_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    bus_i.rd && bus_i.addr != PILR_SERIAL_ADDR && bus_i.addr != PILR_SYSTEM_ADDR
      && bus_i.addr != PILR_ANALOG_ADDR |=> rdata_o == 16'h0000)
    else $error("unmapped read returned data");

  a_idle_rdata: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !bus_i.rd |=> rdata_o == 16'h0000)
    else $error("read data without a read");

  a_read_high_masked: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    bus_i.rd && bus_i.be == 2'h1 |=> rdata_o[15:8] == 8'h00)
    else $error("unselected high byte returned data");

  a_read_low_masked: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    bus_i.rd && bus_i.be == 2'h2 |=> rdata_o[7:0] == 8'h00)
    else $error("unselected low byte returned data");
endmodule : pilr_level_regs
`default_nettype wire

// >>> rtl/pilr_pkg.sv
// Package for the peripheral interrupt level register block
package pilr_pkg;
  localparam logic [15:0] PILR_SERIAL_ADDR = 16'hF026;
  localparam logic [15:0] PILR_SYSTEM_ADDR = 16'hF028;
  localparam logic [15:0] PILR_ANALOG_ADDR = 16'hF02A;
  localparam logic [15:0] PILR_SERIAL_MASK = 16'h3FFF;
  localparam logic [15:0] PILR_SYSTEM_MASK = 16'hFC00;
  localparam logic [15:0] PILR_ANALOG_MASK = 16'h0F0F;
  localparam logic [15:0] PILR_RESET_VAL = 16'h0000;
  localparam int PILR_NSRC = 14;
  localparam int PILR_SERIAL_FIRST = 0;
  localparam int PILR_SYSTEM_FIRST = 7;
  localparam int PILR_ANALOG_FIRST = 10;
  localparam logic [2:0] PILR_SYS_BASE_BIT = 3'h5;
  localparam logic [2:0] PILR_NO_WINNER = 3'h0;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [1:0] be;
  } pilr_bus_req_type;

  typedef struct packed {
    logic [15:0] serial_level;
    logic [15:0] system_level;
    logic [15:0] analog_level;
    logic [15:0] rdata;
    logic [4:0] win_idx;
    logic win_valid;
    logic [2:0] win_level;
  } pilr_state_type;
endpackage : pilr_pkg

// >>> test/pilr_level_regs_tb.sv
// Self-checking bench for the level register block
`timescale 1ns/10ps
`default_nettype none
module pilr_level_regs_tb;
  import pilr_pkg::*;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  pilr_bus_req_type bus = '0;
  logic en = 1'b1;
  logic [PILR_NSRC-1:0] req = '0;
  logic [PILR_NSRC-1:0] pend;
  logic [3:0] isl = 4'h0;
  logic [6:0] sen = 7'h7F;
  logic [PILR_NSRC*2-1:0] lvl;
  logic [15:0] rdata;
  logic wv;
  logic [4:0] wi;
  logic [2:0] wl;
  logic [15:0] expq[$];
  logic [15:0] rnd = 16'h0063;
  int mismatches = 0;
  int comparisons = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  pilr_src_model u_pilr_src_model(.clk_sys_i(clk_sys_i), .req_i(req), .pend_o(pend));
  pilr_level_regs u_pilr_level_regs(.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus_i(bus),
    .level_scheme_enable_i(en), .irq_pend_i(pend), .serial_group_irq_enable_i(sen),
    .system_group_irq_enable_i(3'h7), .analog_group_irq_enable_i(4'hF), .in_service_level_i(isl),
    .rdata_o(rdata), .win_valid_o(wv), .win_idx_o(wi), .win_level_o(wl), .src_level_o(lvl));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic check_win(input logic ev, input logic [4:0] ei, input logic [2:0] el);
    comparisons++;
    if (wv !== ev || (ev && wi !== ei) || wl !== el) begin
      mismatches++;
      $display("MISMATCH at %0t: winner %b %h %h expected %b %h %h", $time, wv, wi, wl, ev, ei, el);
    end
  endtask : check_win
  task automatic complete_run();
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic access(input logic [15:0] a, input logic w, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk_sys_i);
    #2;
    bus = '{addr: a, wdata: d, wr: w, rd: ~w, be: be};
    @(posedge clk_sys_i);
    #2;
    bus.wr = 1'b0;
    bus.rd = 1'b0;
  endtask : access
  task automatic read_reg(input logic [15:0] a, input logic [15:0] exp);
    expq.push_back(exp);
    access(a, 1'b0, 2'h3, 16'h0000);
  endtask : read_reg
  task automatic arb(input logic ev, input logic [4:0] ei, input logic [2:0] el);
    repeat (3) @(posedge clk_sys_i);
    #5;
    check_win(ev, ei, el);
  endtask : arb
  // Read data lags the request by one cycle
  always @(posedge clk_sys_i) begin
    if (bus.rd === 1'b1) begin
      #5;
      check(rdata, expq.pop_front());
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    #2;
    resetn_i = 1'b1;
    read_reg(PILR_SERIAL_ADDR, PILR_RESET_VAL);
    read_reg(PILR_SYSTEM_ADDR, PILR_RESET_VAL);
    read_reg(PILR_ANALOG_ADDR, PILR_RESET_VAL);
    access(PILR_SERIAL_ADDR, 1'b1, 2'h3, 16'hFFFF);
    read_reg(PILR_SERIAL_ADDR, 16'h3FFF);
    access(PILR_SYSTEM_ADDR, 1'b1, 2'h3, 16'hFFFF);
    read_reg(PILR_SYSTEM_ADDR, 16'hFC00);
    access(PILR_ANALOG_ADDR, 1'b1, 2'h3, 16'hFFFF);
    read_reg(PILR_ANALOG_ADDR, 16'h0F0F);
    check(16'(lvl[27:20]), 16'h00FF);
    access(PILR_ANALOG_ADDR, 1'b1, 2'h1, 16'h0000);
    read_reg(PILR_ANALOG_ADDR, 16'h0F00);
    en = 1'b0;
    access(PILR_ANALOG_ADDR, 1'b1, 2'h3, 16'hFFFF);
    read_reg(PILR_ANALOG_ADDR, 16'h0F00);
    en = 1'b1;
    read_reg(16'hF030, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      access(PILR_ANALOG_ADDR, 1'b1, 2'h3, rnd);
      read_reg(PILR_ANALOG_ADDR, rnd & PILR_ANALOG_MASK);
    end
    // Requests stay quiet while levels change
    access(PILR_SERIAL_ADDR, 1'b1, 2'h3, 16'h000D);
    check(16'(lvl[13:0]), 16'h000D);
    req = 14'h0003;
    arb(1'b1, 5'h01, 3'h4);
    isl = 4'h8;
    arb(1'b1, 5'h01, 3'h4);
    req = 14'h0001;
    arb(1'b0, 5'h00, 3'h0);
    sen = 7'h7D;
    isl = 4'h0;
    req = 14'h0003;
    arb(1'b1, 5'h00, 3'h2);
    req = '0;
    access(PILR_ANALOG_ADDR, 1'b1, 2'h3, 16'h0C00);
    req = 14'h2000;
    arb(1'b1, 5'h0D, 3'h4);
    complete_run();
  end
  // A hung run ends well past the expected span of under a hundred cycles
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule : pilr_level_regs_tb
`default_nettype wire

// >>> test/pilr_src_model.sv
// Peripheral request sources facing the level block
`timescale 1ns/10ps
`default_nettype none
module pilr_src_model
  import pilr_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic [PILR_NSRC-1:0] req_i, // Requests to raise
  output var logic [PILR_NSRC-1:0] pend_o // Pending levels
);
  // Sources hold a request as a level, one clock late like a real flag
  always_ff @(posedge clk_sys_i) pend_o <= req_i;
endmodule : pilr_src_model
`default_nettype wire
